// ===== core/dct_map.svh
// Constants of the dual counter/timer: prescaler divisors and reset values.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

// ==========================================================
// Prescaler divisors and select codes
`define DCT_DIV_SYS12    6'h0C
`define DCT_DIV_SYS4     6'h04
`define DCT_DIV_SYS48    6'h30
`define DCT_DIV_EXT8     6'h08
`define DCT_PSEL_SYS12   2'h0
`define DCT_PSEL_SYS4    2'h1
`define DCT_PSEL_SYS48   2'h2
`define DCT_PSEL_EXT8    2'h3

// ==========================================================
// Reset values
`define DCT_COUNT_RESET  8'h00
`define DCT_PIN_IDLE     1'h1

`endif

// ===== core/dct_pkg.sv
// Types shared by the dual counter/timer design files.
// Assumes dct_map.svh is on the include path.
package dct_pkg;

	// ==========================================================
	// Mode field: 13-bit, 16-bit, 8-bit reload, split/inactive
	typedef enum logic [1:0] {
		DCT_MODE_13,
		DCT_MODE_16,
		DCT_MODE_RELOAD,
		DCT_MODE_SPLIT
	} dct_mode_e;

	// Per-timer configuration bits as software sets them.
	typedef struct packed {
		logic      run;
		logic      ext_gating_on;
		logic      counter_function;
		logic      sysclk_select;
		logic      gating_polarity;
		logic      irq_enable;
		dct_mode_e mode;
	} dct_cfg_s;

	// Result of one count step.
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
		logic       ovf;
	} dct_step_s;

endpackage

// ===== core/dct_prescaler.sv
// Shared prescaler: one-cycle tick at sysclk/12, /4, /48 or ext/8.
// Assumes ext_rise is already synchronised to clk.
`timescale 1ns/1ps
`include "dct_map.svh"
module dct_prescaler (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] sel,
	input  wire logic       ext_rise,
	output logic            tick
);
	logic [5:0] cnt_reg, cnt_next, limit;
	logic       tick_reg, tick_next, adv;

	always_comb begin
		if (sel == `DCT_PSEL_SYS12) begin
			limit = `DCT_DIV_SYS12;
		end else if (sel == `DCT_PSEL_SYS4) begin
			limit = `DCT_DIV_SYS4;
		end else if (sel == `DCT_PSEL_SYS48) begin
			limit = `DCT_DIV_SYS48;
		end else begin
			limit = `DCT_DIV_EXT8;
		end
		adv       = (sel == `DCT_PSEL_EXT8) ? ext_rise : 1'b1;
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (adv) begin
			// A range switch to a shorter divisor wraps at once.
			if (cnt_reg >= limit - 6'h01) begin
				cnt_next  = 6'h00;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= 6'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// ===== core/dct_sync_edge.sv
// Two-flop synchroniser with edge detection for one asynchronous pin.
// Assumes a free-running clk and a reset already synchronised.
`timescale 1ns/1ps
module dct_sync_edge #(
	parameter logic IDLE = 1'h1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	logic meta_reg, sync_reg, prev_reg;
	logic meta_next, sync_next, prev_next;

	always_comb begin
		meta_next = pin;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= IDLE;
			sync_reg <= IDLE;
			prev_reg <= IDLE;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// Edge compares two synchronised samples, never the first flop.
	assign level = sync_reg;
	assign fall  = prev_reg & ~sync_reg;
endmodule

// ===== core/dct_top.sv
// Two classic counter/timers, A and B, with shared prescaler.
// Assumes software drives the config ports and byte write strobes
// synchronously to clk; pins and the external clock are asynchronous.
//
// Notes on behaviour
// - Counter function counts each falling edge on the timer event pin.
// - Event rates up to a quarter of the system clock are counted.
// - Each count is 16 bits, written and read as low and high bytes.
// - 13-bit mode uses high byte and low bits 4..0; low 7..5 undefined.
// - 13-bit wrap from all ones sets the overflow flag and interrupt.
// - Timer function clocks from system clock if select is 1, else prescaler.
// - Count only when run is set and gating is off or input active, except A high byte and B during split.
// - Setting run never clears or reloads the count.
// - Timer B mirrors timer A with its own bits and gating input.
// - 16-bit mode counts all sixteen bits, controlled like 13-bit mode.
// - Reload mode: low byte counts, reloads from high byte on wrap, flags.
// - Split mode: A low byte is an 8-bit counter under A controls.
// - Split mode: A high byte times internally under B run, sets B flag.
// - During split, B takes no pin edges and sets no flag or interrupt.
// - During split, B runs in modes 0 to 2 and stops in mode 3.
// - Timer B never counts when its mode field selects mode 3.
// - Mode codes: 13-bit, 16-bit, 8-bit reload, split or inactive.
// - Prescaler gives sysclk /12, /4, /48 or synchronised ext clock /8.
// - Flags clear by software or when the interrupt is vectored.
// - System clock select is ignored while counter function is on, except by the A high byte and by B during split.
`timescale 1ns/1ps
`include "dct_map.svh"
module dct_top
	import dct_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       event_pin_a,
	input  wire logic       event_pin_b,
	input  wire logic       gating_input_a,
	input  wire logic       gating_input_b,
	input  wire logic       ext_clk_in,
	input  wire dct_cfg_s   cfg_a,
	input  wire dct_cfg_s   cfg_b,
	input  wire logic [1:0] shared_prescale_select,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_a_low,
	input  wire logic       wr_a_high,
	input  wire logic       wr_b_low,
	input  wire logic       wr_b_high,
	input  wire logic       flag_clr_a,
	input  wire logic       flag_clr_b,
	input  wire logic       irq_ack_a,
	input  wire logic       irq_ack_b,
	output logic [7:0]      timer_a_count_low,
	output logic [7:0]      timer_a_count_high,
	output logic [7:0]      timer_b_count_low,
	output logic [7:0]      timer_b_count_high,
	output logic            timer_a_overflow_flag,
	output logic            timer_b_overflow_flag,
	output logic            irq_a,
	output logic            irq_b,
	output logic            timer_b_ovf_pulse
);

	// ==========================================================
	// Reset release
	// Assertion is asynchronous but release passes two flops, so every
	// register leaves reset on the same clean edge of clk.
	logic [1:0] rst_pipe_reg;
	logic [1:0] rst_pipe_next;
	logic       rst_core_n;

	always_comb begin
		rst_pipe_next = {rst_pipe_reg[0], 1'b1};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= rst_pipe_next;
		end
	end

	assign rst_core_n = rst_pipe_reg[1];

	// ==========================================================
	// Pin synchronisers and prescaler
	logic evt_a_fall, evt_b_fall;
	logic gate_a_lvl, gate_b_lvl;
	logic ext_lvl, ext_prev_reg, ext_rise;
	logic presc_tick;

	// A level held for two clocks always reaches the second flop, so
	// events up to a quarter of clk each give exactly one falling edge.
	dct_sync_edge #(.IDLE(`DCT_PIN_IDLE)) u_sync_evt_a (
		.clk   (clk),
		.rst_n (rst_core_n),
		.pin   (event_pin_a),
		.level (),
		.fall  (evt_a_fall)
	);

	dct_sync_edge #(.IDLE(`DCT_PIN_IDLE)) u_sync_evt_b (
		.clk   (clk),
		.rst_n (rst_core_n),
		.pin   (event_pin_b),
		.level (),
		.fall  (evt_b_fall)
	);

	dct_sync_edge #(.IDLE(`DCT_PIN_IDLE)) u_sync_gate_a (
		.clk   (clk),
		.rst_n (rst_core_n),
		.pin   (gating_input_a),
		.level (gate_a_lvl),
		.fall  ()
	);

	dct_sync_edge #(.IDLE(`DCT_PIN_IDLE)) u_sync_gate_b (
		.clk   (clk),
		.rst_n (rst_core_n),
		.pin   (gating_input_b),
		.level (gate_b_lvl),
		.fall  ()
	);

	// The external clock is sampled, not used as a clock, so it must
	// run below half of clk, each level longer than one clk, to be divided correctly.
	dct_sync_edge #(.IDLE(1'h0)) u_sync_ext (
		.clk   (clk),
		.rst_n (rst_core_n),
		.pin   (ext_clk_in),
		.level (ext_lvl),
		.fall  ()
	);

	always_ff @(posedge clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_lvl;
		end
	end

	assign ext_rise = ext_lvl & ~ext_prev_reg;

	dct_prescaler u_presc (
		.clk      (clk),
		.rst_n    (rst_core_n),
		.sel      (shared_prescale_select),
		.ext_rise (ext_rise),
		.tick     (presc_tick)
	);

	// ==========================================================
	// Count step shared by both timers
	function automatic dct_step_s dct_step(
		input dct_mode_e  m,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		dct_step_s   r;
		logic [12:0] c13;
		logic [15:0] c16;
		r   = '{hi: hi, lo: lo, ovf: 1'b0};
		c13 = {hi, lo[4:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		// Code 3 is split mode for timer A; timer B never steps in it,
		// because its tick is forced low in that mode.
		case (m)
			DCT_MODE_13: begin
				r.hi  = c13[12:5];
				r.lo  = {lo[7:5], c13[4:0]};
				r.ovf = &{hi, lo[4:0]};
			end
			DCT_MODE_16: begin
				r.hi  = c16[15:8];
				r.lo  = c16[7:0];
				r.ovf = &{hi, lo};
			end
			DCT_MODE_RELOAD: begin
				r.ovf = &lo;
				r.lo  = r.ovf ? hi : lo + 8'h01;
			end
			default: begin
				r.ovf = &lo;
				r.lo  = lo + 8'h01;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// Tick selection and run control
	logic split;
	logic int_tick_a, int_tick_b;
	logic run_a, run_b;
	logic tick_a, tick_ah, tick_b;

	always_comb begin
		split      = (cfg_a.mode == DCT_MODE_SPLIT);
		int_tick_a = cfg_a.sysclk_select ? 1'b1 : presc_tick;
		int_tick_b = cfg_b.sysclk_select ? 1'b1 : presc_tick;
		run_a = cfg_a.run & (~cfg_a.ext_gating_on |
			(gate_a_lvl == cfg_a.gating_polarity));
		run_b = cfg_b.run & (~cfg_b.ext_gating_on |
			(gate_b_lvl == cfg_b.gating_polarity));
		// Counter function overrides the clock select.
		tick_a = run_a &
			(cfg_a.counter_function ? evt_a_fall : int_tick_a);
		tick_ah = split & cfg_b.run & int_tick_a;
		if (cfg_b.mode == DCT_MODE_SPLIT) begin
			tick_b = 1'b0;
		end else if (split) begin
			tick_b = int_tick_b;
		end else begin
			tick_b = run_b &
				(cfg_b.counter_function ? evt_b_fall : int_tick_b);
		end
	end

	// ==========================================================
	// Count registers and flags
	logic [7:0] a_lo_reg, a_hi_reg, b_lo_reg, b_hi_reg;
	logic [7:0] a_lo_next, a_hi_next, b_lo_next, b_hi_next;
	logic       fa_reg, fb_reg, fa_next, fb_next;
	logic       bpulse_reg, bpulse_next;
	logic       set_a, set_b;
	dct_step_s  sa, sb;

	always_comb begin
		sa = dct_step(cfg_a.mode, a_lo_reg, a_hi_reg);
		sb = dct_step(cfg_b.mode, b_lo_reg, b_hi_reg);
		// Run only gates ticks; the stored count is left as it is.
		a_lo_next = a_lo_reg;
		a_hi_next = a_hi_reg;
		b_lo_next = b_lo_reg;
		b_hi_next = b_hi_reg;
		if (tick_a) begin
			a_lo_next = sa.lo;
			if (!split) begin
				a_hi_next = sa.hi;
			end
		end
		if (tick_ah) begin
			a_hi_next = a_hi_reg + 8'h01;
		end
		if (tick_b) begin
			b_lo_next = sb.lo;
			b_hi_next = sb.hi;
		end
		// A software write to a byte wins over a count in that cycle.
		if (wr_a_low) begin
			a_lo_next = wr_data;
		end
		if (wr_a_high) begin
			a_hi_next = wr_data;
		end
		if (wr_b_low) begin
			b_lo_next = wr_data;
		end
		if (wr_b_high) begin
			b_hi_next = wr_data;
		end
		set_a       = tick_a & sa.ovf;
		bpulse_next = tick_b & sb.ovf;
		// In split mode flag B belongs to the high byte of timer A, and
		// the overflow of timer B itself only reaches the pulse output.
		set_b = split ? (tick_ah & (&a_hi_reg)) : bpulse_next;
		fa_next = set_a | (fa_reg & ~(flag_clr_a | irq_ack_a));
		fb_next = set_b | (fb_reg & ~(flag_clr_b | irq_ack_b));
	end

	always_ff @(posedge clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			a_lo_reg   <= `DCT_COUNT_RESET;
			a_hi_reg   <= `DCT_COUNT_RESET;
			b_lo_reg   <= `DCT_COUNT_RESET;
			b_hi_reg   <= `DCT_COUNT_RESET;
			fa_reg     <= 1'b0;
			fb_reg     <= 1'b0;
			bpulse_reg <= 1'b0;
		end else begin
			a_lo_reg   <= a_lo_next;
			a_hi_reg   <= a_hi_next;
			b_lo_reg   <= b_lo_next;
			b_hi_reg   <= b_hi_next;
			fa_reg     <= fa_next;
			fb_reg     <= fb_next;
			bpulse_reg <= bpulse_next;
		end
	end

	// ==========================================================
	// Outputs
	assign timer_a_count_low     = a_lo_reg;
	assign timer_a_count_high    = a_hi_reg;
	assign timer_b_count_low     = b_lo_reg;
	assign timer_b_count_high    = b_hi_reg;
	assign timer_a_overflow_flag = fa_reg;
	assign timer_b_overflow_flag = fb_reg;
	assign timer_b_ovf_pulse     = bpulse_reg;
	assign irq_a = fa_reg & cfg_a.irq_enable;
	assign irq_b = fb_reg & cfg_b.irq_enable;
endmodule

// ===== sim/dct_pm.sv
// Event pin source standing for the world outside both timers.
// Assumes the bench calls pulses from one process at a time.
`timescale 1ns/1ps
module dct_pm (
	input  wire logic  clk,
	output logic [1:0] pin
);
	initial pin = 2'h3;
	// Each level lasts two clocks, the fastest rate the pins accept.
	task automatic pulses(input int t, input int n);
		repeat (n) begin
			@(negedge clk);
			pin[t] = 1'h0;
			repeat (2) @(negedge clk);
			pin[t] = 1'h1;
			@(negedge clk);
		end
	endtask
endmodule

// ===== sim/dct_sva.sv
// Port checks for the dual counter/timer.
// Assumes it is bound into dct_top and that clk runs throughout.
`timescale 1ns/1ps
module dct_sva
	import dct_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire dct_cfg_s   cfg_a,
	input wire dct_cfg_s   cfg_b,
	input wire logic [7:0] wr_data,
	input wire logic       wr_a_low,
	input wire logic       wr_a_high,
	input wire logic       wr_b_low,
	input wire logic       wr_b_high,
	input wire logic       flag_clr_a,
	input wire logic       irq_ack_a,
	input wire logic [7:0] timer_a_count_low,
	input wire logic [7:0] timer_a_count_high,
	input wire logic [7:0] timer_b_count_low,
	input wire logic [7:0] timer_b_count_high,
	input wire logic       timer_a_overflow_flag,
	input wire logic       timer_b_overflow_flag,
	input wire logic       irq_a
);
	logic [15:0] a_cnt;
	logic        a_nw;
	assign a_cnt = {timer_a_count_high, timer_a_count_low};
	assign a_nw = !wr_a_low && !wr_a_high;
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Counting conditions
	sequence s_a16;
		cfg_a.run && !cfg_a.ext_gating_on && !cfg_a.counter_function
		&& cfg_a.sysclk_select && cfg_a.mode == DCT_MODE_16 && a_nw;
	endsequence
	sequence s_brl;
		cfg_b.run && !cfg_b.ext_gating_on && !cfg_b.counter_function
		&& cfg_b.sysclk_select && cfg_b.mode == DCT_MODE_RELOAD
		&& cfg_a.mode != DCT_MODE_SPLIT && !wr_b_low && !wr_b_high;
	endsequence
	AST_A_WR_LO: assert property (wr_a_low |=>
		timer_a_count_low == $past(wr_data)) else $error("write lost");
	AST_B_WR_HI: assert property (wr_b_high |=>
		timer_b_count_high == $past(wr_data)) else $error("write lost");
	AST_A_INC16: assert property (s_a16 |=>
		a_cnt == $past(a_cnt) + 16'h1) else $error("bad increment");
	AST_A_WRAP: assert property (s_a16 ##0 a_cnt == 16'hFFFF |=>
		timer_a_overflow_flag && a_cnt == 16'h0) else $error("no wrap");
	AST_A_HOLD: assert property (!cfg_a.run && a_nw
		&& cfg_a.mode != DCT_MODE_SPLIT |=> $stable(a_cnt))
		else $error("count moved while stopped");
	AST_A_STICKY: assert property (timer_a_overflow_flag
		&& !flag_clr_a && !irq_ack_a |=> timer_a_overflow_flag)
		else $error("flag dropped");
	AST_A_CLR: assert property ((flag_clr_a || irq_ack_a)
		&& !cfg_a.run |=> !timer_a_overflow_flag) else $error("no clear");
	AST_IRQ_A: assert property (irq_a ==
		(timer_a_overflow_flag && cfg_a.irq_enable)) else $error("irq");
	AST_B_RELOAD: assert property (s_brl
		##0 timer_b_count_low == 8'hFF |=>
		timer_b_count_low == $past(timer_b_count_high)
		&& $stable(timer_b_count_high) && timer_b_overflow_flag)
		else $error("reload wrong");
	AST_B_OFF: assert property (cfg_b.mode == DCT_MODE_SPLIT
		&& !wr_b_low && !wr_b_high |=> $stable(timer_b_count_low)
		&& $stable(timer_b_count_high)) else $error("inactive B moved");
	AST_SPLIT_NOFLAG: assert property (cfg_a.mode == DCT_MODE_SPLIT
		&& !cfg_b.run && !timer_b_overflow_flag |=> !timer_b_overflow_flag)
		else $error("B flag set in split");
endmodule
bind dct_top dct_sva u_sva (.clk(clk), .rst_n(rst_n), .cfg_a(cfg_a),
	.cfg_b(cfg_b), .wr_data(wr_data), .wr_a_low(wr_a_low),
	.wr_a_high(wr_a_high), .wr_b_low(wr_b_low), .wr_b_high(wr_b_high),
	.flag_clr_a(flag_clr_a), .irq_ack_a(irq_ack_a),
	.timer_a_count_low(timer_a_count_low),
	.timer_a_count_high(timer_a_count_high),
	.timer_b_count_low(timer_b_count_low),
	.timer_b_count_high(timer_b_count_high),
	.timer_a_overflow_flag(timer_a_overflow_flag),
	.timer_b_overflow_flag(timer_b_overflow_flag), .irq_a(irq_a));

// ===== sim/tb.sv
// Self-checking bench for the dual counter/timer.
// Assumes dct_pm drives the event pins and dct_sva is bound in.
`timescale 1ns/1ps
`include "dct_map.svh"
module tb
	import dct_pkg::*;
;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        ext = 1'h0;
	dct_cfg_s    cfg[2];
	logic [1:0]  psel = 2'h0;
	logic [7:0]  wd = 8'h00;
	logic        wl[2] = '{1'h0, 1'h0};
	logic        wh[2] = '{1'h0, 1'h0};
	logic        fc[2] = '{1'h0, 1'h0};
	logic        ia[2] = '{1'h0, 1'h0};
	logic        gt[2] = '{1'h0, 1'h0};
	logic [1:0]  pin;
	logic [7:0]  lo[2];
	logic [7:0]  hi[2];
	logic        fl[2];
	logic        irq[2];
	logic        pul;
	int          n_pulse = 0;
	logic [15:0] v;
	int          n;
	int          failures = 0;
	int          n_compared = 0;
	int          dv[4] = '{`DCT_DIV_SYS12, `DCT_DIV_SYS4, `DCT_DIV_SYS48,
		3 * `DCT_DIV_EXT8};
	always #5 clk = ~clk;
	// The external clock is offset so its edges never meet clk edges.
	initial begin
		#2;
		forever #15 ext = ~ext;
	end
	always @(negedge clk) if (pul === 1'h1) n_pulse++;
	dct_top u_dut (.clk(clk), .rst_n(rst_n), .event_pin_a(pin[0]),
		.event_pin_b(pin[1]), .gating_input_a(gt[0]),
		.gating_input_b(gt[1]), .ext_clk_in(ext), .cfg_a(cfg[0]),
		.cfg_b(cfg[1]), .shared_prescale_select(psel), .wr_data(wd),
		.wr_a_low(wl[0]), .wr_a_high(wh[0]), .wr_b_low(wl[1]),
		.wr_b_high(wh[1]), .flag_clr_a(fc[0]), .flag_clr_b(fc[1]),
		.irq_ack_a(ia[0]), .irq_ack_b(ia[1]), .timer_a_count_low(lo[0]),
		.timer_a_count_high(hi[0]), .timer_b_count_low(lo[1]),
		.timer_b_count_high(hi[1]), .timer_a_overflow_flag(fl[0]),
		.timer_b_overflow_flag(fl[1]), .irq_a(irq[0]), .irq_b(irq[1]),
		.timer_b_ovf_pulse(pul));
	dct_pm u_pm (.clk(clk), .pin(pin));
	// ==========================================================
	// Helpers
	function automatic dct_step_s adv(logic [1:0] m, logic [15:0] x, int k);
		dct_step_s s;
		logic      o;
		s = {x, 1'h0};
		o = 1'h0;
		repeat (k) begin
			case (m)
			2'h0: {s.ovf, s.hi, s.lo[4:0]} = {1'h0, s.hi, s.lo[4:0]} + 14'h1;
			2'h1: {s.ovf, s.hi, s.lo} = {1'h0, s.hi, s.lo} + 17'h1;
			default: begin
				s.ovf = &s.lo;
				s.lo = s.ovf ? s.hi : s.lo + 8'h1;
			end
			endcase
			o |= s.ovf;
		end
		s.ovf = o;
		return s;
	endfunction
	task automatic tick(int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic chk8(logic [7:0] g, logic [7:0] x);
		n_compared++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic chkb(logic g, logic x);
		n_compared++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic wr(int t, logic [15:0] x);
		@(negedge clk);
		wd = x[7:0];
		wl[t] = 1'h1;
		@(negedge clk);
		wl[t] = 1'h0;
		wh[t] = 1'h1;
		wd = x[15:8];
		@(negedge clk);
		wh[t] = 1'h0;
	endtask
	task automatic run(int t, int k);
		cfg[t].run = 1'h1;
		tick(k);
		cfg[t].run = 1'h0;
	endtask
	task automatic chkc(int t, dct_step_s x, logic [7:0] mk);
		chk8(lo[t] & mk, x.lo & mk);
		chk8(hi[t], x.hi);
		chkb(fl[t], x.ovf);
		chkb(irq[t], x.ovf & cfg[t].irq_enable);
	endtask
	task automatic print_verdict;
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		failures++;
		print_verdict;
	end
	// ==========================================================
	// Scenarios
	initial begin
		cfg[0] = '0;
		cfg[1] = '0;
		n = $urandom(45);
		tick(4);
		rst_n = 1'h1;
		tick(3);
		for (int t = 0; t < 2; t++) chkc(t, '0, 8'hFF);
		for (int t = 0; t < 2; t++) for (int m = 0; m < 3; m++) begin
			cfg[t] = '0;
			cfg[t].sysclk_select = 1'h1;
			cfg[t].mode = dct_mode_e'(m);
			cfg[t].irq_enable = 1'($urandom);
			v = {m == 2 ? 8'($urandom) : 8'hFF, 8'($urandom_range(240, 255))};
			n = $urandom_range(16, 40);
			wr(t, v);
			run(t, n);
			chkc(t, adv(2'(m), v, n), m == 0 ? 8'h1F : 8'hFF);
			if ($urandom_range(0, 1) == 1) fc[t] = 1'h1;
			else ia[t] = 1'h1;
			tick(1);
			fc[t] = 1'h0;
			ia[t] = 1'h0;
			chkb(fl[t], 1'h0);
		end
		cfg[0] = '0;
		cfg[0].mode = DCT_MODE_16;
		for (int p = 0; p < 4; p++) begin
			psel = 2'(p);
			wr(0, 16'h0000);
			tick(48);
			run(0, 2 * dv[p]);
			chk8(lo[0], 8'h02);
		end
		for (int t = 0; t < 2; t++) begin
			cfg[t] = '0;
			cfg[t].counter_function = 1'h1;
			cfg[t].sysclk_select = 1'h1;
			cfg[t].mode = DCT_MODE_16;
			wr(t, 16'h00FE);
			n = $urandom_range(1, 6);
			cfg[t].run = 1'h1;
			u_pm.pulses(t, n);
			tick(6);
			cfg[t].run = 1'h0;
			chkc(t, adv(2'h1, 16'h00FE, n), 8'hFF);
		end
		for (int t = 0; t < 2; t++) for (int g = 0; g < 2; g++) begin
			cfg[t] = '0;
			cfg[t].sysclk_select = 1'h1;
			cfg[t].ext_gating_on = 1'h1;
			cfg[t].mode = DCT_MODE_16;
			cfg[t].gating_polarity = 1'(g);
			gt[t] = ~1'(g);
			wr(t, 16'h0000);
			tick(4);
			run(t, 10);
			chk8(lo[t], 8'h00);
			gt[t] = 1'(g);
			tick(4);
			run(t, 10);
			chk8(lo[t], 8'h0A);
		end
		cfg[0] = '0;
		cfg[0].mode = DCT_MODE_SPLIT;
		cfg[0].sysclk_select = 1'h1;
		cfg[1] = cfg[0];
		wr(0, 16'hFDFE);
		wr(1, 16'hFFFF);
		n = n_pulse;
		cfg[1].mode = DCT_MODE_16;
		cfg[1].counter_function = 1'h1;
		run(0, 4);
		cfg[1].mode = DCT_MODE_SPLIT;
		chk8(lo[0], 8'h02);
		chkb(fl[0], 1'h1);
		chk8(hi[0], 8'hFD);
		chkb(fl[1], 1'h0);
		chk8(8'(n_pulse - n), 8'h01);
		chk8(lo[1], 8'h03);
		run(1, 4);
		chk8(hi[0], 8'h01);
		chkb(fl[1], 1'h1);
		chk8(lo[1], 8'h03);
		print_verdict;
	end
endmodule
